// [hw/exec_defs.svh]
// Purpose: constants for the store-right / trap / system call execute block
// Assumes: 32-bit instruction words, 64-bit datapath
// Notes:   definitions only
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH
`define OP_FUNCTION_CODED    6'h00
`define OP_REGISTER_IMM      6'h01
`define OP_STORE_WORD_RIGHT  6'h2e
`define FN_BARRIER           6'h0f
`define FN_SYSTEM_CALL       6'h0c
`define FN_TRAP_EQ_REG       6'h34
`define FN_TRAP_GE_S_REG     6'h30
`define FN_TRAP_GE_U_REG     6'h31
`define SUB_TRAP_EQ_IMM      5'h0c
`define SUB_TRAP_GE_S_IMM    5'h08
`define SUB_TRAP_GE_U_IMM    5'h09
`define ACCESS_WORD          2'h3
`endif

// [hw/exec_pkg.sv]
// Purpose: shared types for the execute block
// Assumes: nothing
// Notes:   operation classes decoded from one instruction word
package exec_pkg;
   typedef enum logic [2:0] {
      op_none,
      op_store_right,
      op_barrier,
      op_system_call,
      op_trap
   } op_class_e;
endpackage

// [hw/store_right_trap_system_call_op_exec.sv]
// Purpose: execute stage for store-word-right, barrier, system call and eq/ge traps
// Assumes: translation answers in the same cycle; operands already read
// Notes:   one instruction per cycle, results registered
// =====================================================================
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"
module store_right_trap_system_call_op_exec #(
   parameter int PADDR_W = 36
) (
   // clock and reset
   input  wire logic               clk_in,
   input  wire logic               rst_n_in,
   // issued instruction
   input  wire logic               valid_in,
   input  wire logic [31:0]        instr_in,
   input  wire logic [63:0]        first_source_reg_in,
   input  wire logic [63:0]        second_source_reg_in,
   input  wire logic               mode64_in,
   // endian controls
   input  wire logic               memory_endian_flag_in,
   input  wire logic               cpu_endian_flag_in,
   input  wire logic               reverse_endian_flag_in,
   // translation
   output logic [63:0]             xlate_vaddr_out,
   output logic                    xlate_req_out,
   input  wire logic [PADDR_W-1:0] xlate_paddr_in,
   input  wire logic               xlate_uncached_in,
   input  wire logic               xlate_tlb_refill_in,
   input  wire logic               xlate_tlb_invalid_in,
   input  wire logic               xlate_tlb_modify_in,
   input  wire logic               xlate_addr_error_in,
   input  wire logic               mem_bus_error_in,
   // store issue
   output logic                    store_valid_out,
   output logic                    store_uncached_out,
   output logic [1:0]              store_type_out,
   output logic [63:0]             store_data_out,
   output logic [PADDR_W-1:0]      store_paddr_out,
   output logic [63:0]             store_vaddr_out,
   // exceptions and retirement
   output logic                    exc_system_call_out,
   output logic                    exc_trap_out,
   output logic                    exc_tlb_refill_out,
   output logic                    exc_tlb_invalid_out,
   output logic                    exc_tlb_modify_out,
   output logic                    exc_addr_error_out,
   output logic                    exc_bus_error_out,
   output logic                    flush_younger_out,
   output logic                    retire_ok_out
);
   // refused at elaboration: the xor/clear logic needs bits 2..0, vaddr caps at 64
   if (PADDR_W < 4 || PADDR_W > 64) begin
      $error("PADDR_W out of range");
   end

   // =====================================================================
   // decode
   logic [5:0]  primary;
   logic [5:0]  func;
   logic [4:0]  subop;
   logic [63:0] imm_sx;
   logic [63:0] vaddr;
   exec_pkg::op_class_e op_class;
   logic        trap_hit;

   assign primary = instr_in[31:26];
   assign func    = instr_in[5:0];
   assign subop   = instr_in[20:16];
   // code fields 25..6 / 15..6 are never looked at
   assign imm_sx  = {{48{instr_in[15]}}, instr_in[15:0]};

   // 32-bit mode sums and sign-extends the low word
   always_comb begin
      vaddr = first_source_reg_in + imm_sx;
      if (!mode64_in) begin
         vaddr = {{32{vaddr[31]}}, vaddr[31:0]};
      end
   end

   always_comb begin
      op_class = exec_pkg::op_none;
      trap_hit = 1'b0;
      case (primary)
         `OP_STORE_WORD_RIGHT: op_class = exec_pkg::op_store_right;
         `OP_FUNCTION_CODED: begin
            case (func)
               `FN_BARRIER:     op_class = exec_pkg::op_barrier;
               `FN_SYSTEM_CALL: op_class = exec_pkg::op_system_call;
               `FN_TRAP_EQ_REG: begin
                  op_class = exec_pkg::op_trap;
                  trap_hit = first_source_reg_in == second_source_reg_in;
               end
               `FN_TRAP_GE_S_REG: begin
                  op_class = exec_pkg::op_trap;
                  trap_hit = $signed(first_source_reg_in) >= $signed(second_source_reg_in);
               end
               `FN_TRAP_GE_U_REG: begin
                  op_class = exec_pkg::op_trap;
                  trap_hit = {1'b0, first_source_reg_in} >= {1'b0, second_source_reg_in};
               end
               default: op_class = exec_pkg::op_none;
            endcase
         end
         `OP_REGISTER_IMM: begin
            case (subop)
               `SUB_TRAP_EQ_IMM: begin
                  op_class = exec_pkg::op_trap;
                  trap_hit = first_source_reg_in == imm_sx;
               end
               `SUB_TRAP_GE_S_IMM: begin
                  op_class = exec_pkg::op_trap;
                  trap_hit = $signed(first_source_reg_in) >= $signed(imm_sx);
               end
               `SUB_TRAP_GE_U_IMM: begin
                  op_class = exec_pkg::op_trap;
                  trap_hit = first_source_reg_in >= imm_sx;
               end
               default: op_class = exec_pkg::op_none;
            endcase
         end
         default: op_class = exec_pkg::op_none;
      endcase
   end

   // =====================================================================
   // store-right address and data shaping
   logic                is_store;
   logic [1:0]          byte_idx;
   logic [PADDR_W-1:0]  paddr_adj;
   logic [63:0]         data_word;
   logic [63:0]         data_adj;
   logic                xlate_fault;

   assign is_store      = valid_in && op_class == exec_pkg::op_store_right;
   assign xlate_req_out = is_store;
   assign xlate_vaddr_out = vaddr;
   assign byte_idx = vaddr[1:0] ^ {2{cpu_endian_flag_in}};
   // only translation faults count; no alignment check exists here
   assign xlate_fault = xlate_tlb_refill_in | xlate_tlb_invalid_in |
                        xlate_tlb_modify_in | xlate_addr_error_in;

   always_comb begin
      paddr_adj = xlate_paddr_in;
      paddr_adj[2:0] = xlate_paddr_in[2:0] ^ {3{reverse_endian_flag_in}};
      if (!memory_endian_flag_in) begin
         paddr_adj[1:0] = 2'h0;
      end
   end

   always_comb begin
      data_word = {32'h0, second_source_reg_in[31:0]} << {byte_idx, 3'h0};
      data_word = {32'h0, data_word[31:0]};
      if (vaddr[2] ^ cpu_endian_flag_in) begin
         data_adj = {data_word[31:0], 32'h0};
      end else begin
         data_adj = data_word;
      end
   end

   // =====================================================================
   // store issue, squashed on translation fault
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         store_valid_out    <= 1'b0;
         store_uncached_out <= 1'b0;
         store_type_out     <= 2'h0;
         store_data_out     <= 64'h0;
         store_paddr_out    <= '0;
         store_vaddr_out    <= 64'h0;
      end else begin
         store_valid_out    <= is_store && !xlate_fault;
         store_uncached_out <= xlate_uncached_in;
         store_type_out     <= `ACCESS_WORD - byte_idx;
         store_data_out     <= data_adj;
         store_paddr_out    <= paddr_adj;
         store_vaddr_out    <= vaddr;
      end
   end

   // =====================================================================
   // exceptions, one cycle pulses
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         exc_tlb_refill_out  <= 1'b0;
         exc_tlb_invalid_out <= 1'b0;
         exc_tlb_modify_out  <= 1'b0;
         exc_addr_error_out  <= 1'b0;
         exc_bus_error_out   <= 1'b0;
      end else begin
         exc_tlb_refill_out  <= is_store && xlate_tlb_refill_in;
         exc_tlb_invalid_out <= is_store && xlate_tlb_invalid_in;
         exc_tlb_modify_out  <= is_store && xlate_tlb_modify_in;
         exc_addr_error_out  <= is_store && xlate_addr_error_in;
         // bus error reported by memory against the issued store
         exc_bus_error_out   <= store_valid_out && mem_bus_error_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         exc_system_call_out <= 1'b0;
         exc_trap_out        <= 1'b0;
         flush_younger_out   <= 1'b0;
         retire_ok_out       <= 1'b0;
      end else begin
         exc_system_call_out <= valid_in && op_class == exec_pkg::op_system_call;
         exc_trap_out        <= valid_in && op_class == exec_pkg::op_trap && trap_hit;
         // precise: flush and suppress write-back together
         flush_younger_out   <= valid_in && ((op_class == exec_pkg::op_system_call) ||
                                (op_class == exec_pkg::op_trap && trap_hit) ||
                                (is_store && xlate_fault));
         retire_ok_out       <= valid_in && !((op_class == exec_pkg::op_system_call) ||
                                (op_class == exec_pkg::op_trap && trap_hit) ||
                                (is_store && xlate_fault));
      end
   end

   // =====================================================================
   // checks
   property p_store_issue;
      @(posedge clk_in) disable iff (!rst_n_in)
      (valid_in && primary == `OP_STORE_WORD_RIGHT && !xlate_fault) |=> store_valid_out;
   endproperty
   a_store_issue: assert property (p_store_issue) else $error("store not issued");

   property p_no_align_err;
      @(posedge clk_in) disable iff (!rst_n_in)
      (is_store && !xlate_addr_error_in) |=> !exc_addr_error_out;
   endproperty
   a_no_align_err: assert property (p_no_align_err) else $error("alignment error raised");

   property p_le_paddr;
      @(posedge clk_in) disable iff (!rst_n_in)
      (is_store && !memory_endian_flag_in) |=> store_paddr_out[1:0] == 2'h0;
   endproperty
   a_le_paddr: assert property (p_le_paddr) else $error("low paddr bits not cleared");

   property p_type;
      @(posedge clk_in) disable iff (!rst_n_in)
      (is_store && !cpu_endian_flag_in) |=> store_type_out == 2'h3 - $past(vaddr[1:0]);
   endproperty
   a_type: assert property (p_type) else $error("access type wrong");

   property p_barrier;
      @(posedge clk_in) disable iff (!rst_n_in)
      (valid_in && op_class == exec_pkg::op_barrier) |=> (retire_ok_out && !exc_trap_out && !exc_system_call_out);
   endproperty
   a_barrier: assert property (p_barrier) else $error("barrier not a no-op");

   property p_system_call_op;
      @(posedge clk_in) disable iff (!rst_n_in)
      (valid_in && primary == `OP_FUNCTION_CODED && func == `FN_SYSTEM_CALL) |=> exc_system_call_out;
   endproperty
   a_system_call_op: assert property (p_system_call_op) else $error("system call missed");

   property p_teq;
      @(posedge clk_in) disable iff (!rst_n_in)
      (valid_in && primary == `OP_FUNCTION_CODED && func == `FN_TRAP_EQ_REG &&
       first_source_reg_in == second_source_reg_in) |=> exc_trap_out;
   endproperty
   a_teq: assert property (p_teq) else $error("equal trap missed");

   property p_trap_ge_unsigned_reg_op;
      @(posedge clk_in) disable iff (!rst_n_in)
      (valid_in && primary == `OP_FUNCTION_CODED && func == `FN_TRAP_GE_U_REG &&
       first_source_reg_in < second_source_reg_in) |=> !exc_trap_out;
   endproperty
   a_trap_ge_unsigned_reg_op: assert property (p_trap_ge_unsigned_reg_op) else $error("unsigned ge trap false");

   property p_precise;
      @(posedge clk_in) disable iff (!rst_n_in)
      (exc_trap_out || exc_system_call_out) |-> (flush_younger_out && !retire_ok_out);
   endproperty
   a_precise: assert property (p_precise) else $error("exception not precise");

   property p_paddr_high;
      @(posedge clk_in) disable iff (!rst_n_in)
      is_store |=> store_paddr_out[PADDR_W-1:3] == $past(xlate_paddr_in[PADDR_W-1:3]) &&
                   store_paddr_out[2] == $past(xlate_paddr_in[2] ^ reverse_endian_flag_in);
   endproperty
   a_paddr_high: assert property (p_paddr_high) else $error("paddr upper bits wrong");

   property p_data_low;
      @(posedge clk_in) disable iff (!rst_n_in)
      (is_store && vaddr[2:0] == 3'h0 && !cpu_endian_flag_in) |=>
         store_data_out == {32'h0, $past(second_source_reg_in[31:0])};
   endproperty
   a_data_low: assert property (p_data_low) else $error("store data wrong");

   property p_data_high;
      @(posedge clk_in) disable iff (!rst_n_in)
      (is_store && (vaddr[2] ^ cpu_endian_flag_in)) |=> store_data_out[31:0] == 32'h0;
   endproperty
   a_data_high: assert property (p_data_high) else $error("store data not in high half");

   property p_fault_squash;
      @(posedge clk_in) disable iff (!rst_n_in)
      (is_store && xlate_fault) |=> !store_valid_out && !retire_ok_out && flush_younger_out;
   endproperty
   a_fault_squash: assert property (p_fault_squash) else $error("faulting store not squashed");

   property p_trap_equal_imm_op;
      @(posedge clk_in) disable iff (!rst_n_in)
      (valid_in && primary == `OP_REGISTER_IMM && subop == `SUB_TRAP_EQ_IMM &&
       first_source_reg_in == {{48{instr_in[15]}}, instr_in[15:0]}) |=> exc_trap_out;
   endproperty
   a_trap_equal_imm_op: assert property (p_trap_equal_imm_op) else $error("equal immediate trap missed");

   property p_trap_ge_signed_imm_op;
      @(posedge clk_in) disable iff (!rst_n_in)
      (valid_in && primary == `OP_REGISTER_IMM && subop == `SUB_TRAP_GE_S_IMM &&
       $signed(first_source_reg_in) < $signed({{48{instr_in[15]}}, instr_in[15:0]})) |=> !exc_trap_out;
   endproperty
   a_trap_ge_signed_imm_op: assert property (p_trap_ge_signed_imm_op) else $error("signed ge immediate trap false");

   property p_trap_ge_unsigned_imm_op;
      @(posedge clk_in) disable iff (!rst_n_in)
      (valid_in && primary == `OP_REGISTER_IMM && subop == `SUB_TRAP_GE_U_IMM &&
       first_source_reg_in >= {{48{instr_in[15]}}, instr_in[15:0]}) |=> exc_trap_out;
   endproperty
   a_trap_ge_unsigned_imm_op: assert property (p_trap_ge_unsigned_imm_op) else $error("unsigned ge immediate trap missed");

   property p_other_primary;
      @(posedge clk_in) disable iff (!rst_n_in)
      (valid_in && primary != `OP_FUNCTION_CODED && primary != `OP_REGISTER_IMM) |=>
         !exc_trap_out && !exc_system_call_out;
   endproperty
   a_other_primary: assert property (p_other_primary) else $error("trap from wrong primary");
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: self-checking bench for the execute block
// Assumes: partner translates identity, one instruction per cycle
// Notes:   expectations computed from operands, compared one cycle on
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int PW = 36;
   logic          clk_in, rst_n_in, valid_in, mode64_in, mem_e, cpu_e, rev_e, req, unc, bsel, berr;
   logic          sv, su, e_sc, e_tr, e_rf, e_ti, e_tm, e_ae, e_be, fl, ro;
   logic [31:0]   instr_in;
   logic [63:0]   rs_v, rt_v, vaddr, sd, sva, x_data, x_va;
   logic [PW-1:0] paddr, sp, x_pa;
   logic [3:0]    flt, fsel;
   logic [1:0]    st, x_ty;
   logic [7:0]    x_ex;
   logic          x_sv, x_un, berr_a, berr_b;
   int            n_errors, checks;
   // =========================================================
   // instances
   store_right_trap_system_call_op_exec #(.PADDR_W(PW)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .valid_in(valid_in), .instr_in(instr_in), .first_source_reg_in(rs_v), .second_source_reg_in(rt_v),
      .mode64_in(mode64_in), .memory_endian_flag_in(mem_e), .cpu_endian_flag_in(cpu_e),
      .reverse_endian_flag_in(rev_e), .xlate_vaddr_out(vaddr), .xlate_req_out(req), .xlate_paddr_in(paddr),
      .xlate_uncached_in(unc), .xlate_tlb_refill_in(flt[0]), .xlate_tlb_invalid_in(flt[1]),
      .xlate_tlb_modify_in(flt[2]), .xlate_addr_error_in(flt[3]), .mem_bus_error_in(berr),
      .store_valid_out(sv), .store_uncached_out(su), .store_type_out(st), .store_data_out(sd),
      .store_paddr_out(sp), .store_vaddr_out(sva), .exc_system_call_out(e_sc), .exc_trap_out(e_tr),
      .exc_tlb_refill_out(e_rf), .exc_tlb_invalid_out(e_ti), .exc_tlb_modify_out(e_tm),
      .exc_addr_error_out(e_ae), .exc_bus_error_out(e_be), .flush_younger_out(fl), .retire_ok_out(ro));
   xlate_model #(.PADDR_W(PW)) partner (.clk_in(clk_in), .vaddr_in(vaddr), .req_in(req), .store_valid_in(sv),
      .fault_in(fsel), .berr_in(bsel), .paddr_out(paddr), .uncached_out(unc), .fault_out(flt),
      .bus_error_out(berr));
   // =========================================================
   // checking
   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // one cycle: judge last instruction, issue the next, model its result
   task automatic step(input logic v, input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b,
                       input logic [3:0] f, input logic be);
      logic [63:0] ea, si;
      logic [31:0] s32, sh;
      logic [1:0]  bi;
      logic        hit, isst;
      @(posedge clk_in);
      #1;
      check("exc", 64'({e_sc, e_tr, e_rf, e_ti, e_tm, e_ae, fl, ro}), 64'(x_ex));
      check("berr", 64'(e_be), 64'(berr_b));
      check("svalid", 64'(sv), 64'(x_sv));
      if (x_sv) begin
         check("stype", 64'(st), 64'(x_ty));
         check("sdata", sd, x_data);
         check("spaddr", 64'(sp), 64'(x_pa));
         check("svaddr", sva, x_va);
         check("suncached", 64'(su), 64'(x_un));
      end
      berr_b = berr_a;
      {valid_in, instr_in, rs_v, rt_v, fsel, bsel} = {v, ins, a, b, f, be};
      {mode64_in, mem_e, cpu_e, rev_e} = 4'($urandom);
      si = {{48{ins[15]}}, ins[15:0]};
      s32 = a[31:0] + si[31:0];
      ea = mode64_in ? a + si : {{32{s32[31]}}, s32};
      isst = v && ins[31:26] == 6'h2e;
      {x_ex, x_sv, berr_a, hit} = '0;
      if (ins[31:26] == 6'h00) begin
         case (ins[5:0])
            6'h0c: x_ex = 8'h82;
            6'h34: hit = a == b;
            6'h30: hit = $signed(a) >= $signed(b);
            6'h31: hit = {1'b0, a} >= {1'b0, b};
            default: hit = 1'b0;
         endcase
      end
      if (ins[31:26] == 6'h01) begin
         case (ins[20:16])
            5'h0c: hit = a == si;
            5'h08: hit = $signed(a) >= $signed(si);
            5'h09: hit = a >= si;
            default: hit = 1'b0;
         endcase
      end
      if (hit) x_ex = 8'h42;
      if (isst) begin
         x_pa = ea[PW-1:0] ^ PW'({3{rev_e}});
         if (!mem_e) x_pa[1:0] = 2'b00;
         bi = ea[1:0] ^ {2{cpu_e}};
         sh = b[31:0] << (8 * bi);
         x_data = (ea[2] ^ cpu_e) ? {sh, 32'h0} : {32'h0, sh};
         {x_ty, x_va, x_un} = {2'h3 - bi, ea, ea[12]};
         x_ex = {2'b00, f[0], f[1], f[2], f[3], 1'b1, 1'b0};
         if (f == 4'h0) {x_sv, x_ex, berr_a} = {1'b1, 8'h01, be};
      end else if (x_ex == 8'h00) begin
         x_ex = 8'h01;
      end
      if (!v) x_ex = 8'h00;
      #1;
      check("xreq", 64'(req), 64'(isst));
      if (isst) check("xvaddr", vaddr, ea);
   endtask
   function automatic logic [63:0] pick();
      case ($urandom_range(4))
         0: return 64'h0;
         1: return '1;
         2: return 64'h8000_0000_0000_0000;
         3: return 64'h7fff_ffff_ffff_ffff;
         default: return {$urandom, $urandom};
      endcase
   endfunction
   // random mix, back to back; a bus-error store is followed by a bubble
   task automatic run(input int n);
      logic [5:0]  fn [3] = '{6'h34, 6'h30, 6'h31};
      logic [4:0]  sub [4] = '{5'h0c, 5'h08, 5'h09, 5'h0a};
      logic [31:0] ins;
      logic [63:0] a, b;
      logic [3:0]  f;
      logic        be;
      for (int i = 0; i < n; i++) begin
         {a, b, f, be} = {pick(), pick(), 4'h0, 1'b0};
         if ($urandom_range(2) == 0) b = a;
         case ($urandom_range(6))
            0: begin
               ins = {6'h2e, 10'($urandom), 16'($urandom)};
               if ($urandom_range(3) == 0) f = 4'h1 << $urandom_range(3);
               be = f == 4'h0 && $urandom_range(3) == 0;
            end
            1: ins = {6'h00, 20'h0, 6'h0f};
            2: ins = {6'h00, 20'($urandom), 6'h0c};
            3: ins = {6'h00, 20'($urandom), fn[$urandom_range(2)]};
            4: begin
               ins = {6'h01, 5'($urandom), sub[$urandom_range(3)], 16'($urandom)};
               if ($urandom_range(1) == 0) a = {{48{ins[15]}}, ins[15:0]};
            end
            5: ins = {6'h00, 20'($urandom), 6'h3f};
            default: ins = {6'h3b, 26'($urandom)};
         endcase
         step(1'b1, ins, a, b, f, be);
         if (be) step(1'b0, '0, '0, '0, 4'h0, 1'b0);
      end
      step(1'b0, '0, '0, '0, 4'h0, 1'b0);
   endtask
   // =========================================================
   // clock, watchdog and main sequence
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      #800us;
      n_errors++;
      wrap_up();
   end
   initial begin
      void'($urandom(9855));
      {rst_n_in, valid_in, instr_in, rs_v, rt_v, fsel, bsel, mode64_in, mem_e, cpu_e, rev_e} = '0;
      {n_errors, checks, x_ex, x_sv, berr_a, berr_b} = '0;
      repeat (20) @(posedge clk_in);
      #1 rst_n_in = 1'b1;
      run(600);
      // reset in mid-run clears the store valid, exception, flush and retire outputs
      @(posedge clk_in);
      #1 rst_n_in = 1'b0;
      #3;
      check("rst", 64'({sv, e_sc, e_tr, e_rf, e_ti, e_tm, e_ae, e_be, fl, ro}), 64'h0);
      {x_ex, x_sv, berr_a, berr_b} = '0;
      @(posedge clk_in);
      #1 rst_n_in = 1'b1;
      run(200);
      wrap_up();
   end
endmodule
`default_nettype wire

// [sim/xlate_model.sv]
// Purpose: translation and memory partner of the execute block
// Assumes: identity mapping of the low address bits
// Notes:   faults only while a request is up
`timescale 1ns/1ps
`default_nettype none
module xlate_model #(
   parameter int PADDR_W = 36
) (
   // clock
   input  wire logic               clk_in,
   // request side
   input  wire logic [63:0]        vaddr_in,
   input  wire logic               req_in,
   input  wire logic               store_valid_in,
   // fault selection from the bench
   input  wire logic [3:0]         fault_in,
   input  wire logic               berr_in,
   // answers
   output logic [PADDR_W-1:0]      paddr_out,
   output logic                    uncached_out,
   output logic [3:0]              fault_out,
   output logic                    bus_error_out
);
   // =========================================================
   // translation answers
   logic berr_q;
   // idle answer is inverted so a stale sample shows up
   assign paddr_out     = req_in ? vaddr_in[PADDR_W-1:0] : ~vaddr_in[PADDR_W-1:0];
   assign uncached_out  = req_in ? vaddr_in[12] : ~vaddr_in[12];
   assign fault_out     = req_in ? fault_in : 4'h0;
   // =========================================================
   // bus error lands in the store issue cycle
   always_ff @(posedge clk_in) begin
      berr_q <= berr_in & req_in;
   end
   assign bus_error_out = berr_q & store_valid_in;
endmodule
`default_nettype wire
